/* File: rtl/ufs_chan.sv */
// channel slice: level, trigger, flow characters, status and reset state
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] The receive level count reads 0 to 64 characters and ignores writes.
// [RULE2] A written trigger value raises a receive interrupt when the level rises to it.
// [RULE3] Two stop and two resume characters are held in write-only registers.
// [RULE4] The flow character status is forced to zero whenever flow control is off.
// [RULE5] Status bit 3 marks that the last sent flow character was a resume.
// [RULE6] Status bit 2 marks that the last sent flow character was a stop.
// [RULE7] Status bit 1 marks that the last received flow character was a resume.
// [RULE8] Status bit 0 marks that the last received flow character was a stop.
// [RULE9] A host read of the flow character status clears its four bits.
// [RULE10] Reset sets divisor low 0x01, int id 0x01, line 0x60, scratch 0xff, else 0 except the modem status input level bits.
// [RULE11] Reset clears the modem change bits; the upper bits show the input levels.
// [RULE12] Flow control is off when the four select bits are zero, as after reset.
// [RULE13] During reset tx, rts and dtr are high, infrared tx and eeprom pins low.
// [RULE14] A flow event in the cycle of a status read sets its bit despite the clear.
module ufs_chan
    import ufs_pkg::*;
(
    input logic aclk,
    input logic aresetn,
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic rx_fifo_push,
    input logic rx_fifo_pop,
    input logic tx_xon_sent,
    input logic tx_xoff_sent,
    input logic rx_xon_seen,
    input logic rx_xoff_seen,
    input logic tx_serial_bit,
    input logic [3:0] modem_pins,
    output logic serial_tx_out,
    output logic rts_n_out,
    output logic dtr_n_out,
    output logic infrared_tx_out,
    output logic eeprom_clock_out,
    output logic eeprom_select_out,
    output logic eeprom_serial_out,
    output logic [3:0] sw_flow_select,
    output logic [7:0] stop_char_primary,
    output logic [7:0] stop_char_secondary,
    output logic [7:0] resume_char_primary,
    output logic [7:0] resume_char_secondary,
    output logic interrupt_out
);

    // ==========================================================
    // write channel
    ufs_wr_st_t wst_q;
    ufs_wr_st_t wst_d;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic wr_strb_q;

    wire aw_hs = s_axi_awvalid && awready_q;
    wire w_hs = s_axi_wvalid && wready_q;

    always_comb
    begin
        wst_d = wst_q;
        case (wst_q)
            WR_IDLE:
            begin
                if (aw_hs && w_hs)
                    wst_d = WR_EXEC;
                else if (aw_hs)
                    wst_d = WR_ADDR;
                else if (w_hs)
                    wst_d = WR_DATA;
            end
            WR_ADDR: if (w_hs) wst_d = WR_EXEC;
            WR_DATA: if (aw_hs) wst_d = WR_EXEC;
            WR_EXEC: wst_d = WR_RESP;
            WR_RESP: if (s_axi_bready) wst_d = WR_IDLE;
            default: wst_d = WR_IDLE;
        endcase
    end

    wire wr_en = (wst_q == WR_EXEC) && wr_strb_q;
    wire we_trig = wr_en && (wr_addr_q == OFS_RX_TRIG);
    wire we_stop1 = wr_en && (wr_addr_q == OFS_STOP1);
    wire we_stop2 = wr_en && (wr_addr_q == OFS_STOP2);
    wire we_res1 = wr_en && (wr_addr_q == OFS_RESUME1);
    wire we_res2 = wr_en && (wr_addr_q == OFS_RESUME2);
    wire we_feat = wr_en && (wr_addr_q == OFS_FEAT);
    wire we_iclr = wr_en && (wr_addr_q == OFS_IRQ_CLR);
    wire we_ien = wr_en && (wr_addr_q == OFS_IRQ_EN);
    wire we_scr = wr_en && (wr_addr_q == OFS_SCRATCH);
    wire we_dlo = wr_en && (wr_addr_q == OFS_DIV_LO);
    wire we_dhi = wr_en && (wr_addr_q == OFS_DIV_HI);
    wire we_mctl = wr_en && (wr_addr_q == OFS_MODEM_CTRL);
    wire we_ee = wr_en && (wr_addr_q == OFS_EEPROM);
    // read-only offsets are mapped and take writes without effect
    wire wr_hit = (wr_addr_q[1:0] == 2'b00) && (wr_addr_q <= OFS_EEPROM);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wst_q <= WR_IDLE;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else
        begin
            wst_q <= wst_d;
            awready_q <= (wst_d == WR_IDLE) || (wst_d == WR_DATA);
            wready_q <= (wst_d == WR_IDLE) || (wst_d == WR_ADDR);
            bvalid_q <= (wst_d == WR_RESP);
            if (wst_q == WR_EXEC)
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_addr_q <= RST_ZERO;
            wr_data_q <= RST_ZERO;
            wr_strb_q <= 1'b0;
        end
        else
        begin
            if (aw_hs)
                wr_addr_q <= s_axi_awaddr;
            if (w_hs)
            begin
                wr_data_q <= s_axi_wdata[7:0];
                wr_strb_q <= s_axi_wstrb[0];
            end
        end
    end

    // ==========================================================
    // configuration registers
    logic [7:0] trig_q;
    logic [7:0] stop1_q;
    logic [7:0] stop2_q;
    logic [7:0] res1_q;
    logic [7:0] res2_q;
    logic [7:0] feat_q;
    logic [IRQ_W-1:0] ien_q;
    logic [7:0] scr_q;
    logic [7:0] dlo_q;
    logic [7:0] dhi_q;
    logic [7:0] mctl_q;
    logic [2:0] ee_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_q <= RST_ZERO; // [RULE10]
            stop1_q <= RST_ZERO;
            stop2_q <= RST_ZERO;
            res1_q <= RST_ZERO;
            res2_q <= RST_ZERO;
        end
        else
        begin
            if (we_trig) trig_q <= wr_data_q; // [RULE2]
            if (we_stop1) stop1_q <= wr_data_q; // [RULE3]
            if (we_stop2) stop2_q <= wr_data_q; // [RULE3]
            if (we_res1) res1_q <= wr_data_q; // [RULE3]
            if (we_res2) res2_q <= wr_data_q; // [RULE3]
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            feat_q <= RST_ZERO; // [RULE12]
            ien_q <= '0;
            scr_q <= RST_SCRATCH; // [RULE10]
            dlo_q <= RST_DIV_LO; // [RULE10]
            dhi_q <= RST_ZERO;
            mctl_q <= RST_ZERO;
            ee_q <= 3'h0; // [RULE13]
        end
        else
        begin
            if (we_feat) feat_q <= wr_data_q;
            if (we_ien) ien_q <= wr_data_q[IRQ_W-1:0];
            if (we_scr) scr_q <= wr_data_q;
            if (we_dlo) dlo_q <= wr_data_q;
            if (we_dhi) dhi_q <= wr_data_q;
            if (we_mctl) mctl_q <= wr_data_q;
            if (we_ee) ee_q <= wr_data_q[2:0];
        end
    end

    // ==========================================================
    // receive level and trigger
    logic [7:0] rx_level;
    logic rx_reach;

    ufs_level_cnt u_rx_level (
        .clk(aclk),
        .rst_n(aresetn),
        .push(rx_fifo_push),
        .pop(rx_fifo_pop),
        .trigger(trig_q),
        .level(rx_level),
        .reached(rx_reach)
    );

    // ==========================================================
    // modem inputs: two-stage sync, then change detect
    logic [3:0] mdm_s1_q;
    logic [3:0] mdm_s2_q;
    logic [3:0] mdm_s3_q;
    logic [3:0] mdm_dlt_q;

    always_ff @(posedge aclk)
    begin
        mdm_s1_q <= modem_pins;
        mdm_s2_q <= mdm_s1_q;
        mdm_s3_q <= mdm_s2_q;
    end

    // ==========================================================
    // read channel
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wire ar_hs = s_axi_arvalid && arready_q;
    wire rd_flow = ar_hs && (s_axi_araddr == OFS_FLOW_STAT);
    wire rd_mstat = ar_hs && (s_axi_araddr == OFS_MODEM_STAT);
    wire rd_hit = (s_axi_araddr[1:0] == 2'b00) &&
                  (s_axi_araddr <= OFS_EEPROM);

    logic [3:0] fcs_q;
    logic [3:0] fcs_d;
    logic [IRQ_W-1:0] ists_q;
    logic [IRQ_W-1:0] ists_d;
    logic [7:0] int_id_q;
    wire [7:0] a = s_axi_araddr;
    wire [7:0] rd_mux =
        (a == OFS_RX_LEVEL) ? rx_level : // [RULE1]
        (a == OFS_FLOW_STAT) ? {4'h0, fcs_q} :
        (a == OFS_FEAT) ? feat_q :
        (a == OFS_IRQ_STAT) ? {4'h0, ists_q} :
        (a == OFS_IRQ_EN) ? {4'h0, ien_q} :
        (a == OFS_SCRATCH) ? scr_q :
        (a == OFS_DIV_LO) ? dlo_q :
        (a == OFS_DIV_HI) ? dhi_q :
        (a == OFS_LINE_STAT) ? RST_LINE_STAT :
        (a == OFS_INT_ID) ? int_id_q :
        (a == OFS_MODEM_STAT) ? {mdm_s2_q, mdm_dlt_q} : // [RULE11]
        (a == OFS_MODEM_CTRL) ? mctl_q :
        (a == OFS_EEPROM) ? {5'h00, ee_q} : RST_ZERO;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_mux};
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ==========================================================
    // flow character status
    wire flow_en = |feat_q[FEAT_FLOW_MSB:0]; // [RULE12]

    always_comb
    begin
        fcs_d = rd_flow ? 4'h0 : fcs_q; // [RULE9]
        if (tx_xoff_sent)
            fcs_d[3:2] = 2'b01; // [RULE6]
        else if (tx_xon_sent)
            fcs_d[3:2] = 2'b10; // [RULE5]
        if (rx_xoff_seen)
            fcs_d[1:0] = 2'b01; // [RULE8]
        else if (rx_xon_seen)
            fcs_d[1:0] = 2'b10; // [RULE7]
        if (!flow_en)
            fcs_d = 4'h0; // [RULE4]
    end

    // ==========================================================
    // interrupt status, enable and clear
    wire [IRQ_W-1:0] ev = {|(mdm_s2_q ^ mdm_s3_q),
                           rx_xon_seen && flow_en,
                           rx_xoff_seen && flow_en,
                           rx_reach};
    wire [IRQ_W-1:0] clr = we_iclr ? wr_data_q[IRQ_W-1:0] : '0;
    assign ists_d = (ists_q & ~clr) | ev; // [RULE2]
    wire [3:0] dlt_d = (rd_mstat ? 4'h0 : mdm_dlt_q) |
                       (mdm_s2_q ^ mdm_s3_q);
    logic irq_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fcs_q <= 4'h0; // [RULE10]
            ists_q <= '0;
            int_id_q <= RST_INT_ID; // [RULE10]
            mdm_dlt_q <= 4'h0; // [RULE11]
            irq_q <= 1'b0;
        end
        else
        begin
            fcs_q <= fcs_d; // [RULE14]
            ists_q <= ists_d;
            int_id_q <= (ists_d[IRQ_RX_TRIG] && ien_q[IRQ_RX_TRIG]) ?
                        INT_ID_RX_TRIG : RST_INT_ID;
            mdm_dlt_q <= dlt_d;
            irq_q <= |(ists_d & ien_q);
        end
    end

    // ==========================================================
    // serial side outputs
    logic tx_q;
    logic rts_n_q;
    logic dtr_n_q;
    logic ir_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_q <= 1'b1; // [RULE13]
            rts_n_q <= 1'b1; // [RULE13]
            dtr_n_q <= 1'b1; // [RULE13]
            ir_q <= 1'b0; // [RULE13]
        end
        else
        begin
            tx_q <= tx_serial_bit;
            rts_n_q <= ~mctl_q[MCTL_RTS];
            dtr_n_q <= ~mctl_q[MCTL_DTR];
            ir_q <= mctl_q[MCTL_IR] & ~tx_serial_bit;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign serial_tx_out = tx_q;
    assign rts_n_out = rts_n_q;
    assign dtr_n_out = dtr_n_q;
    assign infrared_tx_out = ir_q;
    assign eeprom_clock_out = ee_q[EE_CLK];
    assign eeprom_select_out = ee_q[EE_CS];
    assign eeprom_serial_out = ee_q[EE_DATA];
    assign sw_flow_select = feat_q[3:0];
    assign stop_char_primary = stop1_q;
    assign stop_char_secondary = stop2_q;
    assign resume_char_primary = res1_q;
    assign resume_char_secondary = res2_q;
    assign interrupt_out = irq_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire any_ev = tx_xon_sent | tx_xoff_sent | rx_xon_seen | rx_xoff_seen;

    property p_level_max;
        rx_level <= FIFO_DEPTH;
    endproperty
    a_level_max: assert property (p_level_max) // [RULE1]
        else $error("rx level above depth");

    property p_level_step;
        rx_fifo_push && !rx_fifo_pop && rx_level < FIFO_DEPTH
            |=> rx_level == $past(rx_level) + 8'h01;
    endproperty
    a_level_step: assert property (p_level_step) // [RULE1]
        else $error("rx level did not step");

    property p_trig_irq;
        rx_fifo_push && !rx_fifo_pop && rx_level < FIFO_DEPTH &&
            rx_level + 8'h01 == trig_q |=> ##1 ists_q[IRQ_RX_TRIG];
    endproperty
    a_trig_irq: assert property (p_trig_irq) // [RULE2]
        else $error("trigger level missed");

    property p_char_wr;
        we_stop1 |=> stop_char_primary == $past(wr_data_q);
    endproperty
    a_char_wr: assert property (p_char_wr) // [RULE3]
        else $error("stop character not stored");

    property p_flow_off;
        !flow_en |=> fcs_q == 4'h0;
    endproperty
    a_flow_off: assert property (p_flow_off) // [RULE4]
        else $error("status not cleared while flow off");

    property p_tx_xon;
        flow_en && tx_xon_sent && !tx_xoff_sent |=> fcs_q[3:2] == 2'b10;
    endproperty
    a_tx_xon: assert property (p_tx_xon) // [RULE5]
        else $error("sent resume not marked");

    property p_tx_xoff;
        flow_en && tx_xoff_sent |=> fcs_q[3:2] == 2'b01;
    endproperty
    a_tx_xoff: assert property (p_tx_xoff) // [RULE6]
        else $error("sent stop not marked");

    property p_rx_xon;
        flow_en && rx_xon_seen && !rx_xoff_seen |=> fcs_q[1:0] == 2'b10;
    endproperty
    a_rx_xon: assert property (p_rx_xon) // [RULE7]
        else $error("received resume not marked");

    property p_rx_xoff;
        flow_en && rx_xoff_seen |=> ##0 fcs_q[1:0] == 2'b01;
    endproperty
    a_rx_xoff: assert property (p_rx_xoff) // [RULE8]
        else $error("received stop not marked");

    property p_rd_clr;
        rd_flow && !any_ev |=> fcs_q == 4'h0 && s_axi_rvalid;
    endproperty
    a_rd_clr: assert property (p_rd_clr) // [RULE9]
        else $error("status read did not clear");

    property p_set_wins;
        flow_en && rd_flow && rx_xoff_seen |=> fcs_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) // [RULE14]
        else $error("event lost to read clear");

    property p_rst_regs;
        disable iff (1'b0)
        !aresetn |=> scr_q == RST_SCRATCH && dlo_q == RST_DIV_LO &&
            int_id_q == RST_INT_ID && feat_q == RST_ZERO &&
            trig_q == RST_ZERO &&
            mdm_dlt_q == 4'h0;
    endproperty
    a_rst_regs: assert property (p_rst_regs) // [RULE10]
        else $error("register reset value wrong");

    property p_rst_pins;
        disable iff (1'b0)
        !aresetn |=> serial_tx_out && rts_n_out && dtr_n_out &&
            !infrared_tx_out && !eeprom_clock_out && !eeprom_select_out &&
            !eeprom_serial_out;
    endproperty
    a_rst_pins: assert property (p_rst_pins) // [RULE13]
        else $error("pin reset state wrong");

    c_trig: cover property (rx_reach ##2 interrupt_out);
    c_flow_rd: cover property (fcs_q != 4'h0 ##1 rd_flow);
    c_wr_resp: cover property (s_axi_bvalid && s_axi_bready);

endmodule

/* File: rtl/ufs_level_cnt.sv */
// receive fifo level counter with trigger detection
`timescale 1ns/100ps
module ufs_level_cnt
    import ufs_pkg::*;
(
    input logic clk,
    input logic rst_n,
    input logic push,
    input logic pop,
    input logic [7:0] trigger,
    output logic [7:0] level,
    output logic reached
);

    logic [7:0] level_q;
    logic [7:0] level_d;
    logic reach_q;

    // ==========================================================
    // count step, held within 0 .. depth
    wire do_inc = push && !pop && (level_q < FIFO_DEPTH);
    wire do_dec = pop && !push && (level_q != RST_ZERO);
    assign level_d = do_inc ? level_q + 8'h01 :
                     do_dec ? level_q - 8'h01 : level_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            level_q <= RST_ZERO;
            reach_q <= 1'b0;
        end
        else
        begin
            level_q <= level_d; // [RULE1]
            reach_q <= do_inc && (level_d == trigger); // [RULE2]
        end
    end

    assign level = level_q;
    assign reached = reach_q;

endmodule

/* File: rtl/ufs_pkg.sv */
// package: register map, reset values and constants of the channel slice
package ufs_pkg;

    // ==========================================================
    // sizes
    localparam logic [7:0] FIFO_DEPTH = 8'h40;
    localparam int IRQ_W = 4;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_RX_LEVEL = 8'h00;
    localparam logic [7:0] OFS_RX_TRIG = 8'h04;
    localparam logic [7:0] OFS_STOP1 = 8'h08;
    localparam logic [7:0] OFS_STOP2 = 8'h0c;
    localparam logic [7:0] OFS_RESUME1 = 8'h10;
    localparam logic [7:0] OFS_RESUME2 = 8'h14;
    localparam logic [7:0] OFS_FLOW_STAT = 8'h18;
    localparam logic [7:0] OFS_FEAT = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
    localparam logic [7:0] OFS_IRQ_EN = 8'h28;
    localparam logic [7:0] OFS_SCRATCH = 8'h2c;
    localparam logic [7:0] OFS_DIV_LO = 8'h30;
    localparam logic [7:0] OFS_DIV_HI = 8'h34;
    localparam logic [7:0] OFS_LINE_STAT = 8'h38;
    localparam logic [7:0] OFS_INT_ID = 8'h3c;
    localparam logic [7:0] OFS_MODEM_STAT = 8'h40;
    localparam logic [7:0] OFS_MODEM_CTRL = 8'h44;
    localparam logic [7:0] OFS_EEPROM = 8'h48;

    // ==========================================================
    // values after reset, and the rx trigger interrupt id
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DIV_LO = 8'h01;
    localparam logic [7:0] RST_INT_ID = 8'h01;
    localparam logic [7:0] RST_LINE_STAT = 8'h60;
    localparam logic [7:0] RST_SCRATCH = 8'hff;
    localparam logic [7:0] INT_ID_RX_TRIG = 8'h04;

    // ==========================================================
    // field positions
    localparam int FEAT_FLOW_MSB = 3;
    localparam int MCTL_DTR = 0;
    localparam int MCTL_RTS = 1;
    localparam int MCTL_IR = 6;
    localparam int EE_CLK = 0;
    localparam int EE_CS = 1;
    localparam int EE_DATA = 2;
    localparam int IRQ_RX_TRIG = 0;
    localparam int IRQ_RX_XOFF = 1;
    localparam int IRQ_RX_XON = 2;
    localparam int IRQ_MODEM = 3;

    // ==========================================================
    // bus answers and write states
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        WR_IDLE = 3'b000,
        WR_ADDR = 3'b001,
        WR_DATA = 3'b010,
        WR_EXEC = 3'b011,
        WR_RESP = 3'b100
    } ufs_wr_st_t;

endpackage

/* File: test/tb_top.sv */
// testbench for the channel slice
`timescale 1ns/100ps
module tb_top;
    import ufs_pkg::*;
    // ========
    // signals
    logic aclk;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rrsp;
    logic [31:0] rdata, rdat;
    logic push, pop, txon, txoff, rxon, rxoff, txbit;
    logic txo, rtsn, dtrn, iro, eck, ecs, eso;
    logic [3:0] modem, sel;
    logic [7:0] s1, s2, r1, r2;
    int n_errors = 0;
    int compares = 0;
    localparam logic [7:0] RA [7] = '{OFS_DIV_LO, OFS_INT_ID, OFS_LINE_STAT,
        OFS_SCRATCH, OFS_FLOW_STAT, OFS_RX_LEVEL, OFS_FEAT};
    localparam logic [7:0] RV [7] = '{RST_DIV_LO, RST_INT_ID, RST_LINE_STAT,
        RST_SCRATCH, RST_ZERO, RST_ZERO, RST_ZERO};
    ufs_chan DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_fifo_push(push), .rx_fifo_pop(pop),
        .tx_xon_sent(txon), .tx_xoff_sent(txoff), .rx_xon_seen(rxon),
        .rx_xoff_seen(rxoff), .tx_serial_bit(txbit), .modem_pins(modem),
        .serial_tx_out(txo), .rts_n_out(rtsn), .dtr_n_out(dtrn),
        .infrared_tx_out(iro), .eeprom_clock_out(eck),
        .eeprom_select_out(ecs), .eeprom_serial_out(eso),
        .sw_flow_select(sel), .stop_char_primary(s1),
        .stop_char_secondary(s2), .resume_char_primary(r1),
        .resume_char_secondary(r2), .interrupt_out(irq));
    ufs_peer peer (.aclk(aclk), .push(push), .pop(pop), .txon(txon),
        .txoff(txoff), .rxon(rxon), .rxoff(rxoff), .txbit(txbit),
        .modem(modem));
    initial
    begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end
    // ========
    // bus and check tasks
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        begin
            compares++;
            if (g !== e)
            begin
                $display("mismatch %s exp %h got %h", n, e, g);
                n_errors++;
            end
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        begin
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            tb = 1'h0;
            while (!tb)
            begin
                @(negedge aclk);
                ta = awvalid & awready;
                tw = wvalid & wready;
                tb = bvalid;
                rrsp = bresp;
                @(posedge aclk);
                if (ta) awvalid <= 1'h0;
                if (tw) wvalid <= 1'h0;
            end
            bready <= 1'h0;
            @(posedge aclk);
        end
    endtask
    task rd(input logic [7:0] a);
        logic ta, tr;
        begin
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            tr = 1'h0;
            while (!tr)
            begin
                @(negedge aclk);
                ta = arvalid & arready;
                tr = rvalid;
                rdat = rdata;
                rrsp = rresp;
                @(posedge aclk);
                if (ta) arvalid <= 1'h0;
            end
            rready <= 1'h0;
            @(posedge aclk);
        end
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        begin
            rd(a);
            chk($sformatf("reg %h", a), e, rdat);
        end
    endtask
    task ck_irq(input logic e);
        begin
            repeat (4) @(posedge aclk);
            @(negedge aclk);
            chk("irq", {31'h0, e}, {31'h0, irq});
            @(posedge aclk);
        end
    endtask
    // ========
    // scenarios
    task t_reset;
        int i;
        begin
            for (i = 0; i < 7; i++)
                rc(RA[i], {24'h0, RV[i]});
            rc(OFS_MODEM_STAT, 32'ha0);
            rd(8'h4c);
            chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rrsp});
            wr(8'h4c, 8'h00);
            chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rrsp});
            $display("test reset done");
        end
    endtask
    task t_level;
        begin
            wr(OFS_RX_TRIG, 8'h02);
            peer.send(0, 2);
            ck_irq(1'h0);
            rc(OFS_IRQ_STAT, 32'h1);
            wr(OFS_IRQ_EN, 8'h01);
            ck_irq(1'h1);
            rc(OFS_INT_ID, {24'h0, INT_ID_RX_TRIG});
            wr(OFS_IRQ_CLR, 8'h01);
            ck_irq(1'h0);
            peer.send(0, 70);
            wr(OFS_RX_LEVEL, 8'h05);
            rc(OFS_RX_LEVEL, 32'h40);
            ck_irq(1'h0);
            peer.send(1, 70);
            rc(OFS_RX_LEVEL, 32'h0);
            $display("test level done");
        end
    endtask
    task t_chars;
        begin
            wr(OFS_STOP1, 8'h11);
            wr(OFS_STOP2, 8'h22);
            wr(OFS_RESUME1, 8'h33);
            wr(OFS_RESUME2, 8'h44);
            wr(OFS_FEAT, 8'h0f);
            @(negedge aclk);
            chk("chars", 32'h11223344, {s1, s2, r1, r2});
            chk("sel", 32'hf, {28'h0, sel});
            @(posedge aclk);
            rc(OFS_STOP1, 32'h0);
            $display("test chars done");
        end
    endtask
    task t_flow;
        int i;
        begin
            for (i = 2; i < 6; i++)
            begin
                peer.send(i, 1);
                rc(OFS_FLOW_STAT, 32'h1 << (5 - i));
                rc(OFS_FLOW_STAT, 32'h0);
            end
            peer.send(2, 1);
            peer.send(3, 1);
            rc(OFS_FLOW_STAT, 32'h4);
            fork
                peer.send(5, 1);
                rc(OFS_FLOW_STAT, 32'h0);
            join
            rc(OFS_FLOW_STAT, 32'h1);
            peer.send(5, 1);
            wr(OFS_FEAT, 8'h00);
            rc(OFS_FLOW_STAT, 32'h0);
            peer.send(4, 1);
            rc(OFS_FLOW_STAT, 32'h0);
            $display("test flow done");
        end
    endtask
    task final_report;
        begin
            $display("counts %0d compares %0d mismatches", compares, n_errors);
            if (n_errors == 0 && compares > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial
    begin
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk("pins", 32'h70, {25'h0, txo, rtsn, dtrn, iro, eck, ecs, eso});
        @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset;
        t_level;
        t_chars;
        t_flow;
        final_report;
    end
    initial
    begin
        repeat (8000) @(posedge aclk);
        n_errors++;
        final_report;
    end
endmodule

/* File: test/ufs_peer.sv */
// remote side model: fifo and flow-control event pulses
`timescale 1ns/100ps
module ufs_peer (
    input wire logic aclk,
    output logic push,
    output logic pop,
    output logic txon,
    output logic txoff,
    output logic rxon,
    output logic rxoff,
    output logic txbit,
    output logic [3:0] modem
);
    // ========
    // event lines
    logic [5:0] ev = 6'h00;
    assign {rxoff, rxon, txoff, txon, pop, push} = ev;
    assign txbit = 1'h1;
    assign modem = 4'ha;
    // n back-to-back pulses on event line i
    task send(input int i, input int n);
        begin
            ev[i] <= 1'h1;
            repeat (n) @(posedge aclk);
            ev[i] <= 1'h0;
            @(posedge aclk);
        end
    endtask
endmodule
